/* common/dma_pkg.sv */
// Purpose: Shared constants and carrier types for the data memory addressing.
// Assumes: One request per clock from the core's execution unit.
// Notes: Special function addresses and field positions live here; the core's checks repeat some as literals.
package dma_pkg;

  // Access kinds chosen by the instruction's operand type.
  typedef enum logic [2:0] {
    MODE_DIRECT,
    MODE_INDIRECT,
    MODE_REG,
    MODE_BIT,
    MODE_PUSH,
    MODE_POP,
    MODE_XRAM8,
    MODE_XRAM16
  } dma_mode_t;

  // One access request from the execution unit.
  typedef struct packed {
    logic valid;
    dma_mode_t mode;
    logic we;
    logic [7:0] addr;
    logic [7:0] addr_hi;
    logic [7:0] wdata;
    logic bit_val;
  } dma_req_t;

  // Special function register port towards the peripherals.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [2:0] bitpos;
    logic bit_acc;
    logic we;
    logic re;
  } dma_sfr_t;

  // External data memory port, also carrying flash writes.
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
    logic flash_we;
  } dma_xram_t;

  // Special function addresses handled inside this block.
  localparam logic [7:0] SFR_SP_ADDR = 8'h81;
  localparam logic [7:0] SFR_PSW_ADDR = 8'hd0;
  localparam logic [7:0] SFR_PAGE_ADDR = 8'he7;

  // Reset values.
  localparam logic [7:0] SP_RST = 8'h07;
  localparam logic [7:0] PSW_RST = 8'h00;
  localparam logic [3:0] PAGE_RST = 4'h0;

  // Field positions and layout.
  localparam int BANK_LSB = 3;
  localparam int SPACE_BIT = 7;
  localparam logic [3:0] BIT_REGION_HI = 4'h2;
  localparam logic [7:0] SP_STEP = 8'h01;

endpackage : dma_pkg

/* rtl/dma_core.sv */
// Purpose: Internal data RAM, register banks, bit space, stack and paging.
// Assumes: Peripherals answer an SFR or XRAM read in the cycle it is issued.
// Notes: Local reads answer one cycle after the request, port reads two.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Locations 0x00 to 0x1F form four banks of eight byte registers.
// - Two status word bank bits pick the single active bank.
// - Indirect modes take their address from R0 or R1 of the bank.
// - Bytes 0x20 to 0x2F also act as 128 bits, addresses 0x00-0x7F.
// - Bit address selects byte 0x20 plus address/8, bit by low three bits.
// - Bit or byte access follows the operand type, not the address.
// - Stack pointer marks last used; push writes above it then increments.
// - Reset sets stack pointer to 0x07, first push lands at 0x08.
// - Stack may sit anywhere in the 256 bytes and span all of them.
// - RAM past 256 bytes is reached only by external moves.
// - A 16-bit external write may instead write flash.
// - Page register sits at 0xE7; bits 7:4 reserved and read zero.
// - Page field bits 3:0, reset zero, give the 8-bit move high byte.
// - Direct accesses to 0x80-0xFF go to special function registers.
// - Only SFRs at addresses ending 0x0 or 0x8 are bit addressable.
// - Indirect accesses above 0x7F reach the upper 128 RAM bytes.
module dma_core (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Request from the execution unit.
  input wire dma_pkg::dma_req_t req_i,
  input wire logic flash_wr_en_i,
  // Read answer to the execution unit.
  output logic rd_valid_o,
  output logic [7:0] rd_data_o,
  // Special function register port.
  output dma_pkg::dma_sfr_t sfr_o,
  input wire logic [7:0] sfr_rdata_i,
  // External data memory port.
  output dma_pkg::dma_xram_t xram_o,
  input wire logic [7:0] xram_rdata_i
);

  // Byte address of a bit address, in RAM or in the SFR space.
  function automatic logic [7:0] bit_byte(input logic [7:0] b);
    if (b[dma_pkg::SPACE_BIT]) begin
      bit_byte = {1'b1, b[6:3], 3'b000};
    end else begin
      bit_byte = {dma_pkg::BIT_REGION_HI, b[6:3]};
    end
  endfunction : bit_byte

  logic [7:0] ram [256];
  logic [7:0] sp_q;
  logic [7:0] psw_q;
  logic [3:0] page_q;
  logic rd_valid_q;
  logic [7:0] rd_data_q;
  logic [7:0] rd_data_d;
  logic pend_q;
  logic pend_xram_q;
  logic pend_bit_q;
  logic [2:0] pend_pos_q;
  dma_pkg::dma_sfr_t sfr_q;
  dma_pkg::dma_xram_t xram_q;
  logic [1:0] bank;
  logic [7:0] ptr_idx;
  logic [7:0] ind_addr;
  logic [7:0] reg_idx;
  logic [7:0] sp_inc;
  logic [7:0] dir_addr;
  logic [7:0] dir_byte;
  logic [7:0] loc_sfr;
  logic is_dir;
  logic is_sfr;
  logic is_loc;
  logic ext_sfr;
  logic wr_sfr;
  logic rd_req;
  logic [7:0] ext_byte;

  // Address decode; the operand type alone picks bit or byte handling.
  assign bank = psw_q[dma_pkg::BANK_LSB +: 2];
  assign ptr_idx = {3'b000, bank, 2'b00, req_i.addr[0]};
  assign ind_addr = ram[ptr_idx];
  assign reg_idx = {3'b000, bank, req_i.addr[2:0]};
  assign sp_inc = sp_q + dma_pkg::SP_STEP;
  assign is_dir = (req_i.mode == dma_pkg::MODE_DIRECT) ||
                  (req_i.mode == dma_pkg::MODE_BIT);
  assign dir_addr = (req_i.mode == dma_pkg::MODE_BIT) ?
                    bit_byte(req_i.addr) : req_i.addr;
  assign is_sfr = is_dir && dir_addr[dma_pkg::SPACE_BIT];
  assign is_loc = (dir_addr == dma_pkg::SFR_SP_ADDR) ||
                  (dir_addr == dma_pkg::SFR_PSW_ADDR) ||
                  (dir_addr == dma_pkg::SFR_PAGE_ADDR);
  assign ext_sfr = req_i.valid && is_sfr && !is_loc;
  assign wr_sfr = req_i.valid && req_i.we && is_sfr;
  assign rd_req = req_i.valid && !req_i.we &&
                  (req_i.mode != dma_pkg::MODE_PUSH);
  assign dir_byte = is_sfr ? loc_sfr : ram[dir_addr];
  assign ext_byte = pend_xram_q ? xram_rdata_i : sfr_rdata_i;

  // Read view of the SFRs held here; reserved page bits read zero.
  always_comb begin
    unique case (dir_addr)
      dma_pkg::SFR_SP_ADDR: loc_sfr = sp_q;
      dma_pkg::SFR_PSW_ADDR: loc_sfr = psw_q;
      dma_pkg::SFR_PAGE_ADDR: loc_sfr = {4'h0, page_q};
      default: loc_sfr = 8'h00;
    endcase
  end

  // Local read data for the answer one cycle later.
  always_comb begin
    unique case (req_i.mode)
      dma_pkg::MODE_DIRECT: rd_data_d = dir_byte;
      dma_pkg::MODE_BIT: rd_data_d = {7'h00, dir_byte[req_i.addr[2:0]]};
      dma_pkg::MODE_INDIRECT: rd_data_d = ram[ind_addr];
      dma_pkg::MODE_REG: rd_data_d = ram[reg_idx];
      dma_pkg::MODE_POP: rd_data_d = ram[sp_q];
      default: rd_data_d = 8'h00;
    endcase
  end

  // RAM writes; contents are not cleared by reset on purpose.
  always_ff @(posedge clk_i) begin
    if (req_i.valid && !rst_i) begin
      unique case (req_i.mode)
        dma_pkg::MODE_DIRECT: begin
          if (req_i.we && !is_sfr) begin
            ram[dir_addr] <= req_i.wdata;
          end
        end
        dma_pkg::MODE_INDIRECT: begin
          if (req_i.we) begin
            ram[ind_addr] <= req_i.wdata;
          end
        end
        dma_pkg::MODE_REG: begin
          if (req_i.we) begin
            ram[reg_idx] <= req_i.wdata;
          end
        end
        dma_pkg::MODE_BIT: begin
          if (req_i.we && !is_sfr) begin
            ram[dir_addr][req_i.addr[2:0]] <= req_i.bit_val;
          end
        end
        dma_pkg::MODE_PUSH: ram[sp_inc] <= req_i.wdata;
        default: begin
        end
      endcase
    end
  end

  // Stack pointer; push and pop win over a direct write in the same cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sp_q <= dma_pkg::SP_RST;
    end else if (req_i.valid && req_i.mode == dma_pkg::MODE_PUSH) begin
      sp_q <= sp_inc;
    end else if (req_i.valid && req_i.mode == dma_pkg::MODE_POP) begin
      sp_q <= sp_q - dma_pkg::SP_STEP;
    end else if (wr_sfr && dir_addr == dma_pkg::SFR_SP_ADDR &&
                 req_i.mode == dma_pkg::MODE_DIRECT) begin
      sp_q <= req_i.wdata;
    end
  end

  // Status word holding the bank select bits; it takes bit writes too.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      psw_q <= dma_pkg::PSW_RST;
    end else if (wr_sfr && dir_addr == dma_pkg::SFR_PSW_ADDR) begin
      if (req_i.mode == dma_pkg::MODE_BIT) begin
        psw_q[req_i.addr[2:0]] <= req_i.bit_val;
      end else begin
        psw_q <= req_i.wdata;
      end
    end
  end

  // Page register; only the low field is stored, so the rest reads zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      page_q <= dma_pkg::PAGE_RST;
    end else if (wr_sfr && dir_addr == dma_pkg::SFR_PAGE_ADDR &&
                 req_i.mode == dma_pkg::MODE_DIRECT) begin
      page_q <= req_i.wdata[3:0];
    end
  end

  // SFR port for registers kept in the peripherals.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sfr_q <= '0;
    end else begin
      sfr_q.addr <= dir_addr;
      sfr_q.wdata <= (req_i.mode == dma_pkg::MODE_BIT) ?
                     {7'h00, req_i.bit_val} : req_i.wdata;
      sfr_q.bitpos <= req_i.addr[2:0];
      sfr_q.bit_acc <= (req_i.mode == dma_pkg::MODE_BIT);
      sfr_q.we <= ext_sfr && req_i.we;
      sfr_q.re <= ext_sfr && !req_i.we;
    end
  end

  // External memory port; a 16-bit write may be steered to flash.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      xram_q <= '0;
    end else begin
      xram_q.we <= 1'b0;
      xram_q.re <= 1'b0;
      xram_q.flash_we <= 1'b0;
      xram_q.wdata <= req_i.wdata;
      if (req_i.valid && req_i.mode == dma_pkg::MODE_XRAM8) begin
        xram_q.addr <= {4'h0, page_q, ind_addr};
        xram_q.we <= req_i.we;
        xram_q.re <= !req_i.we;
      end else if (req_i.valid && req_i.mode == dma_pkg::MODE_XRAM16) begin
        xram_q.addr <= {req_i.addr_hi, req_i.addr};
        xram_q.we <= req_i.we && !flash_wr_en_i;
        xram_q.flash_we <= req_i.we && flash_wr_en_i;
        xram_q.re <= !req_i.we;
      end
    end
  end

  // Answer path; port reads are captured one cycle after issue.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_valid_q <= 1'b0;
      rd_data_q <= 8'h00;
      pend_q <= 1'b0;
      pend_xram_q <= 1'b0;
      pend_bit_q <= 1'b0;
      pend_pos_q <= 3'h0;
    end else begin
      pend_q <= rd_req && (ext_sfr || req_i.mode == dma_pkg::MODE_XRAM8 ||
                           req_i.mode == dma_pkg::MODE_XRAM16);
      pend_xram_q <= !is_dir;
      pend_bit_q <= (req_i.mode == dma_pkg::MODE_BIT);
      pend_pos_q <= req_i.addr[2:0];
      if (pend_q) begin
        rd_valid_q <= 1'b1;
        rd_data_q <= pend_bit_q ? {7'h00, ext_byte[pend_pos_q]} : ext_byte;
      end else begin
        rd_valid_q <= rd_req && !ext_sfr &&
                      req_i.mode != dma_pkg::MODE_XRAM8 &&
                      req_i.mode != dma_pkg::MODE_XRAM16;
        rd_data_q <= rd_data_d;
      end
    end
  end

  assign rd_valid_o = rd_valid_q;
  assign rd_data_o = rd_data_q;
  assign sfr_o = sfr_q;
  assign xram_o = xram_q;

  // Checks on the addressing behaviour.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_sp_reset_val: assert property ($fell(rst_i) |-> sp_q == 8'h07)
    else $error("stack pointer not 0x07 after reset");
  a_push_order: assert property (req_i.valid &&
      req_i.mode == dma_pkg::MODE_PUSH |=> sp_q == $past(sp_q) + 8'h01 &&
      ram[sp_q] == $past(req_i.wdata))
    else $error("push did not write above and advance stack");
  a_pop_order: assert property (req_i.valid && !pend_q &&
      req_i.mode == dma_pkg::MODE_POP |=> sp_q == $past(sp_q) - 8'h01 &&
      rd_valid_o && rd_data_o == ram[$past(sp_q)])
    else $error("pop wrong data or pointer");
  a_bank_write: assert property (req_i.valid && req_i.we &&
      req_i.mode == dma_pkg::MODE_REG |=>
      ram[{3'b000, $past(bank), $past(req_i.addr[2:0])}] ==
      $past(req_i.wdata))
    else $error("register write missed active bank");
  a_bit_map: assert property (req_i.valid && req_i.we && !req_i.addr[7] &&
      req_i.mode == dma_pkg::MODE_BIT |=>
      ram[{4'h2, $past(req_i.addr[6:3])}][$past(req_i.addr[2:0])] ==
      $past(req_i.bit_val))
    else $error("bit write hit wrong byte or bit");
  a_page_high: assert property (req_i.valid &&
      req_i.mode == dma_pkg::MODE_XRAM8 |=>
      xram_o.addr[15:8] == {4'h0, $past(page_q)})
    else $error("page field not on high address byte");
  a_page_rsvd: assert property (req_i.valid && !req_i.we && !pend_q &&
      req_i.mode == dma_pkg::MODE_DIRECT && req_i.addr == 8'he7 |=>
      rd_valid_o && rd_data_o[7:4] == 4'h0)
    else $error("reserved page bits not zero");
  a_sfr_route: assert property (ext_sfr |=> (sfr_o.we || sfr_o.re) &&
      sfr_o.addr[7])
    else $error("direct upper access not sent to SFR port");
  a_flash_steer: assert property (req_i.valid && req_i.we && flash_wr_en_i &&
      req_i.mode == dma_pkg::MODE_XRAM16 |=>
      xram_o.flash_we && !xram_o.we)
    else $error("16-bit write not steered to flash");
  a_sfr_bit_byte: assert property (req_i.valid && req_i.addr[7] &&
      req_i.mode == dma_pkg::MODE_BIT |=> sfr_o.addr[2:0] == 3'h0)
    else $error("bit access to SFR not x0 or x8");

  c_push: cover property (req_i.valid && req_i.mode == dma_pkg::MODE_PUSH);
  c_bit_write: cover property (req_i.valid && req_i.we &&
      req_i.mode == dma_pkg::MODE_BIT);
  c_xram_read: cover property (xram_o.re ##1 rd_valid_o);
  c_sfr_read: cover property (sfr_o.re ##1 rd_valid_o);

endmodule : dma_core

`default_nettype wire

/* test/data_memory_addressing_test.sv */
// Purpose: Self-checking bench for the data memory addressing block.
// Assumes: One request at a time, driven at the falling edge.
// Notes: A peripheral model answers special function and external reads.
`timescale 1ns/1ps
`default_nettype none
module data_memory_addressing_test;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic flash_wr_en_i = 1'b0;
  dma_pkg::dma_req_t req_i = '0;
  logic rd_valid_o;
  logic [7:0] rd_data_o;
  dma_pkg::dma_sfr_t sfr_o;
  dma_pkg::dma_xram_t xram_o;
  logic [7:0] sfr_rdata_i;
  logic [7:0] xram_rdata_i;
  int errors = 0;
  int samples_checked = 0;
  logic [7:0] bit_addrs [4] = '{8'h00, 8'h07, 8'h13, 8'h7f};

  // Clock at 100 ns period.
  always #50 clk_i = ~clk_i;

  dma_core i_dma_core (.clk_i(clk_i), .rst_i(rst_i), .req_i(req_i),
    .flash_wr_en_i(flash_wr_en_i), .rd_valid_o(rd_valid_o),
    .rd_data_o(rd_data_o), .sfr_o(sfr_o), .sfr_rdata_i(sfr_rdata_i),
    .xram_o(xram_o), .xram_rdata_i(xram_rdata_i));
  dma_periph_model i_dma_periph_model (.clk_i(clk_i), .sfr_i(sfr_o),
    .xram_i(xram_o), .sfr_rdata_o(sfr_rdata_i), .xram_rdata_o(xram_rdata_i));

  task automatic results;
    $display("checked %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Holds the request over one rising edge and returns at the next falling
  // edge, while the one-cycle strobes launched by that edge still stand.
  task automatic iss(input dma_pkg::dma_mode_t m, input logic w,
      input logic [7:0] a, input logic [7:0] d, input logic b = 1'b0,
      input logic [7:0] hi = 8'h00);
    @(negedge clk_i);
    req_i = '{valid: 1'b1, mode: m, we: w, addr: a, addr_hi: hi, wdata: d,
      bit_val: b};
    @(negedge clk_i);
    req_i.valid = 1'b0;
  endtask : iss

  // External reads answer a cycle later than local ones, hence the short wait.
  task automatic rd(input dma_pkg::dma_mode_t m, input logic [7:0] a,
      input logic [7:0] e, input logic [7:0] hi = 8'h00);
    int n;
    iss(m, 1'b0, a, 8'h00, 1'b0, hi);
    n = 0;
    while (rd_valid_o !== 1'b1 && n < 3) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    if (rd_valid_o !== 1'b1) begin
      chk(16'(rd_valid_o), 16'h0001);
      results();
    end else begin
      chk(16'(rd_data_o), 16'(e));
    end
  endtask : rd

  task automatic do_reset;
    @(negedge clk_i);
    rst_i = 1'b1;
    repeat (6) @(negedge clk_i);
    rst_i = 1'b0;
  endtask : do_reset

  task automatic t_stack;
    rd(dma_pkg::MODE_DIRECT, dma_pkg::SFR_SP_ADDR, 8'h07);
    iss(dma_pkg::MODE_PUSH, 1'b1, 8'h00, 8'ha5);
    rd(dma_pkg::MODE_DIRECT, dma_pkg::SFR_SP_ADDR, 8'h08);
    rd(dma_pkg::MODE_DIRECT, 8'h08, 8'ha5);
    rd(dma_pkg::MODE_POP, 8'h00, 8'ha5);
    rd(dma_pkg::MODE_DIRECT, dma_pkg::SFR_SP_ADDR, 8'h07);
    $display("stack test done");
  endtask : t_stack

  task automatic t_banks;
    for (int b = 0; b < 4; b++) begin
      iss(dma_pkg::MODE_DIRECT, 1'b1, dma_pkg::SFR_PSW_ADDR, 8'(b * 8));
      iss(dma_pkg::MODE_REG, 1'b1, 8'h03, 8'(16 + b));
    end
    for (int b = 0; b < 4; b++)
      rd(dma_pkg::MODE_DIRECT, 8'(b * 8 + 3), 8'(16 + b));
    iss(dma_pkg::MODE_DIRECT, 1'b1, dma_pkg::SFR_PSW_ADDR, 8'h10);
    iss(dma_pkg::MODE_REG, 1'b1, 8'h01, 8'h85);
    iss(dma_pkg::MODE_INDIRECT, 1'b1, 8'h01, 8'hc3);
    rd(dma_pkg::MODE_INDIRECT, 8'h01, 8'hc3);
    rd(dma_pkg::MODE_DIRECT, 8'h85, 8'h85);
    iss(dma_pkg::MODE_DIRECT, 1'b1, dma_pkg::SFR_PSW_ADDR, 8'h00);
    $display("bank test done");
  endtask : t_banks

  task automatic t_bits;
    iss(dma_pkg::MODE_DIRECT, 1'b1, 8'h20, 8'h00);
    iss(dma_pkg::MODE_DIRECT, 1'b1, 8'h22, 8'h00);
    iss(dma_pkg::MODE_DIRECT, 1'b1, 8'h2f, 8'h00);
    foreach (bit_addrs[i])
      iss(dma_pkg::MODE_BIT, 1'b1, bit_addrs[i], 8'h00, 1'b1);
    rd(dma_pkg::MODE_DIRECT, 8'h20, 8'h81);
    rd(dma_pkg::MODE_DIRECT, 8'h22, 8'h08);
    rd(dma_pkg::MODE_DIRECT, 8'h2f, 8'h80);
    rd(dma_pkg::MODE_BIT, 8'h13, 8'h01);
    rd(dma_pkg::MODE_DIRECT, 8'h13, 8'h12);
    // An occupied port-like register; unoccupied addresses are left alone.
    iss(dma_pkg::MODE_BIT, 1'b1, 8'h93, 8'h00, 1'b1);
    chk(16'({sfr_o.we, sfr_o.bit_acc, sfr_o.bitpos}), 16'h001b);
    chk(16'(sfr_o.addr), 16'h0090);
    rd(dma_pkg::MODE_DIRECT, 8'h90, 8'h98);
    iss(dma_pkg::MODE_BIT, 1'b1, 8'hd3, 8'h00, 1'b1);
    rd(dma_pkg::MODE_DIRECT, dma_pkg::SFR_PSW_ADDR, 8'h08);
    rd(dma_pkg::MODE_REG, 8'h03, 8'h11);
    iss(dma_pkg::MODE_DIRECT, 1'b1, dma_pkg::SFR_PSW_ADDR, 8'h00);
    $display("bit test done");
  endtask : t_bits

  task automatic t_xram;
    rd(dma_pkg::MODE_DIRECT, dma_pkg::SFR_PAGE_ADDR, 8'h00);
    iss(dma_pkg::MODE_DIRECT, 1'b1, dma_pkg::SFR_PAGE_ADDR, 8'hfa);
    rd(dma_pkg::MODE_DIRECT, dma_pkg::SFR_PAGE_ADDR, 8'h0a);
    iss(dma_pkg::MODE_REG, 1'b1, 8'h00, 8'h34);
    iss(dma_pkg::MODE_XRAM8, 1'b1, 8'h00, 8'h77);
    chk(16'(xram_o.we), 16'h0001);
    chk(xram_o.addr, 16'h0a34);
    rd(dma_pkg::MODE_XRAM8, 8'h00, 8'h77);
    iss(dma_pkg::MODE_XRAM16, 1'b1, 8'h12, 8'h3c, 1'b0, 8'h0b);
    chk(16'({xram_o.we, xram_o.flash_we}), 16'h0002);
    chk(xram_o.addr, 16'h0b12);
    flash_wr_en_i = 1'b1;
    iss(dma_pkg::MODE_XRAM16, 1'b1, 8'h12, 8'h4d, 1'b0, 8'h0b);
    chk(16'({xram_o.we, xram_o.flash_we}), 16'h0001);
    flash_wr_en_i = 1'b0;
    rd(dma_pkg::MODE_XRAM16, 8'h12, 8'h3c, 8'h0b);
    $display("external test done");
  endtask : t_xram

  task automatic t_wrap;
    // Stack moved to the top so the second push wraps round into R0 of bank 0.
    iss(dma_pkg::MODE_DIRECT, 1'b1, dma_pkg::SFR_SP_ADDR, 8'hfe);
    iss(dma_pkg::MODE_PUSH, 1'b1, 8'h00, 8'hd1);
    iss(dma_pkg::MODE_PUSH, 1'b1, 8'h00, 8'hd2);
    rd(dma_pkg::MODE_DIRECT, 8'h00, 8'hd2);
    iss(dma_pkg::MODE_REG, 1'b1, 8'h00, 8'hff);
    rd(dma_pkg::MODE_INDIRECT, 8'h00, 8'hd1);
    rd(dma_pkg::MODE_DIRECT, dma_pkg::SFR_SP_ADDR, 8'h00);
    do_reset();
    rd(dma_pkg::MODE_DIRECT, dma_pkg::SFR_SP_ADDR, 8'h07);
    rd(dma_pkg::MODE_DIRECT, dma_pkg::SFR_PAGE_ADDR, 8'h00);
    $display("wrap test done");
  endtask : t_wrap

  // Main sequence.
  initial begin
    do_reset();
    t_stack();
    t_banks();
    t_bits();
    t_xram();
    t_wrap();
    results();
  end
endmodule : data_memory_addressing_test
`default_nettype wire

/* test/dma_periph_model.sv */
// Purpose: Peripheral and external memory stand-in for the addressing block.
// Assumes: Reads are answered combinationally while the read strobe is high.
// Notes: Idle read lines show the inverse of the last answer, never old data.
`timescale 1ns/1ps
`default_nettype none
module dma_periph_model (
  // Clock.
  input wire logic clk_i,
  // Ports from the addressing block.
  input wire dma_pkg::dma_sfr_t sfr_i,
  input wire dma_pkg::dma_xram_t xram_i,
  // Read answers.
  output logic [7:0] sfr_rdata_o,
  output logic [7:0] xram_rdata_o
);
  logic [7:0] sfr_mem [128];
  logic [7:0] xram_mem [4096];
  logic [7:0] sfr_last_q;
  logic [7:0] xram_last_q;

  // Each register starts out holding its own address, so a read shows which.
  initial begin
    for (int i = 0; i < 128; i++) sfr_mem[i] = 8'(i + 128);
    for (int i = 0; i < 4096; i++) xram_mem[i] = 8'(i);
    sfr_last_q = 8'h00;
    xram_last_q = 8'h00;
  end

  // Writes land at the clock edge; a bit write changes one bit only.
  always @(posedge clk_i) begin
    if (sfr_i.we && sfr_i.bit_acc) begin
      sfr_mem[sfr_i.addr[6:0]][sfr_i.bitpos] <= sfr_i.wdata[0];
    end else if (sfr_i.we) begin
      sfr_mem[sfr_i.addr[6:0]] <= sfr_i.wdata;
    end
    if (xram_i.we) xram_mem[xram_i.addr[11:0]] <= xram_i.wdata;
    if (sfr_i.re) sfr_last_q <= sfr_rdata_o;
    if (xram_i.re) xram_last_q <= xram_rdata_o;
  end

  // Released lines toggle away from the last value so stale data cannot pass.
  assign sfr_rdata_o = sfr_i.re ? sfr_mem[sfr_i.addr[6:0]] : ~sfr_last_q;
  assign xram_rdata_o = xram_i.re ? xram_mem[xram_i.addr[11:0]] : ~xram_last_q;
endmodule : dma_periph_model
`default_nettype wire
